// *** logic/icg_pkg.sv ***
// Shared constants and types for the idle clock and module gating block.
// Assumes a single 10 MHz clock domain and an AXI4-Lite register port.
package icg_pkg;

	// Register map (byte addresses, one 32-bit word each)
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFF_OSC_CTRL  = 8'h00;
	localparam logic [7:0]  OFF_OSC_STAT  = 8'h04;
	localparam logic [7:0]  OFF_PWR_CTRL  = 8'h08;
	localparam logic [7:0]  OFF_MDIS0     = 8'h0C;
	localparam logic [7:0]  OFF_MDIS1     = 8'h10;
	localparam logic [7:0]  OFF_MDIS2     = 8'h14;
	localparam logic [7:0]  OFF_PERIPH_EN = 8'h18;

	// Peripheral layout: three module-disable registers of eight bits
	localparam int          MDIS_W        = 8;
	localparam int          NUM_MDIS      = 3;
	localparam int          NUM_PERIPH    = MDIS_W * NUM_MDIS;

	// Reset values
	localparam logic [7:0]  OSC_CTRL_RST  = 8'h00;
	localparam logic [1:0]  PWR_CTRL_RST  = 2'h0;
	localparam logic [7:0]  MDIS_RST      = 8'h00;
	localparam logic [23:0] PERIPH_EN_RST = 24'h000000;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Timing: figures in ns, cycles derived (least times round up)
	localparam int CLK_PERIOD_NS    = 100;
	localparam int SETTLE_TIME_NS   = 1000;
	localparam int SWITCH_DELAY_NS  = 2000;
	localparam int PRIMARY_START_NS = 1000;
	localparam int SETTLE_CYC_RAW   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SWITCH_CYC_RAW   = (SWITCH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRIMARY_CYC_RAW  = (PRIMARY_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC       = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
	localparam int SWITCH_CYC       = (SWITCH_CYC_RAW < 1) ? 1 : SWITCH_CYC_RAW;
	localparam int PRIMARY_CYC      = (PRIMARY_CYC_RAW < 1) ? 1 : PRIMARY_CYC_RAW;

	// Oscillator control word, bit 3 reserved and reads zero
	typedef struct packed {
		logic       intSrcSel;
		logic [2:0] freqSel;
		logic       rsvd;
		logic       clkSrcSelHi;
		logic       clkSrcSelLo;
		logic       idleSelect;
	} icg_osc_ctrl_t;

	// Oscillator status word
	typedef struct packed {
		logic [2:0] rsvd;
		logic       inIdle;
		logic       cpuRun;
		logic       intOscOn;
		logic       intOscStable;
		logic       oscStartup;
	} icg_osc_stat_t;

	// Power modes handled here
	typedef enum logic [1:0] {
		PM_RUN,
		PM_IDLE,
		PM_WAKE
	} icg_pmode_t;

endpackage

// *** logic/icg_delay_timer.sv ***
// Delay timer: done rises once run has been high for CYCLES+1 edges.
// Assumes run is a synchronous level; dropping run restarts the count.
`timescale 1ns/1ps
module icg_delay_timer
	import icg_pkg::*;
#(
	parameter int CYCLES = 10
)
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic resetn,
	// Control
	input  wire logic run,
	output logic      done
);

	localparam int CNT_W = $clog2(CYCLES + 1);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             atEnd;

	// Saturating count, cleared whenever run drops
	assign atEnd    = (cnt_reg == CNT_W'(CYCLES));
	assign cnt_next = !run ? '0 : (atEnd ? cnt_reg : cnt_reg + 1'b1);

	// Counter and registered done
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_reg <= '0;
			done    <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			done    <= run & atEnd;
		end
	end

endmodule

// *** logic/icg_periph_gate.sv ***
// Per-peripheral gate: clock enable, active level and write gating.
// Assumes disable and enable bits come from registers on the same clock.
`timescale 1ns/1ps
module icg_periph_gate
	import icg_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic resetn,
	// Control bits
	input  wire logic disableBit,
	input  wire logic enableBit,
	input  wire logic wrReq,
	// Gated outputs
	output logic      clkEn,
	output logic      active,
	output logic      wrEn
);

	// Disable wins over enable; clearing enable alone keeps registers writable
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			clkEn  <= 1'b0;
			active <= 1'b0;
			wrEn   <= 1'b0;
		end
		else
		begin
			clkEn  <= ~disableBit;
			active <= ~disableBit & enableBit;
			wrEn   <= wrReq & ~disableBit;
		end
	end

endmodule

// *** logic/icg_clock_ctrl.sv ***
// Idle clock control and per-peripheral module gating, AXI4-Lite slave.
// Assumes core pulses sleepExec/wakeEvent on this clock; one clock domain.
// Functional notes
// - Idle stops CPU clock, peripherals keep clocking.
// - Sleep with idle select and clkSrcSelHi set enters idle mode.
// - Frequency field chosen before sleep is held; nonzero only requests the oscillator.
// - Internal source selected: primary off, startup cleared.
// - Nonzero freq or source bit: oscillator on, flags.
// - Peripheral clocks continue while oscillator stabilizes.
// - Stable flags stay set across idle entry.
// - All zero: oscillator off, flags stay clear.
// - Wake: CPU resumes after clock switch delay.
// - Wake leaves idle and source bits untouched.
// - Watchdog or fail-safe keeps internal oscillator running.
// - Enable clear stops function, registers stay accessible.
// - Module disable gates the clock of the disabled peripheral only.
// - Module disable blocks peripheral register writes.
// - Three module-disable registers of per-peripheral bits.
`timescale 1ns/1ps
module icg_clock_ctrl
	import icg_pkg::*;
#(
	parameter int N_PERIPH = NUM_PERIPH
)
(
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                resetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]   awaddr,
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output logic                     wready,
	// AXI4-Lite write response
	output logic [1:0]               bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]   araddr,
	input  wire logic                arvalid,
	output logic                     arready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp,
	output logic                     rvalid,
	input  wire logic                rready,
	// Core events
	input  wire logic                sleepExec,
	input  wire logic                wakeEvent,
	// Clock tree controls
	output logic                     cpuClkEn,
	output logic                     cpuClkFromIntOsc,
	output logic                     primaryOscEn,
	output logic                     intOscEn,
	output logic                     intOscStable,
	// Peripheral gating
	input  wire logic [N_PERIPH-1:0] periphWrReq,
	output logic [N_PERIPH-1:0]      periphClkEn,
	output logic [N_PERIPH-1:0]      periphActive,
	output logic [N_PERIPH-1:0]      periphWrEn
);

	// Software-visible registers
	icg_osc_ctrl_t              oscCtrl_reg;
	logic [1:0]                 pwrCtrl_reg;
	logic [MDIS_W-1:0]          mdis_reg [NUM_MDIS];
	logic [N_PERIPH-1:0]        periphEn_reg;
	icg_pmode_t                 mode_reg;
	icg_pmode_t                 mode_next;

	// Bus slave state
	logic                       awHeld_reg;
	logic [ADDR_W-1:0]          awAddr_reg;
	logic                       wHeld_reg;
	logic [31:0]                wData_reg;
	logic [3:0]                 wStrb_reg;

	// Wires
	logic                       awHs;
	logic                       wHs;
	logic                       bHs;
	logic                       arHs;
	logic                       rHs;
	logic                       doWrite;
	logic [31:0]                wMask;
	logic                       wrOscCtrl;
	logic                       wrPwrCtrl;
	logic                       wrPeriphEn;
	logic                       wrHit;
	logic                       rdHit;
	logic [31:0]                rdValue;
	logic [31:0]                oscCtrlMerged;
	logic [31:0]                pwrCtrlMerged;
	logic [31:0]                periphEnMerged;
	logic [NUM_MDIS*MDIS_W-1:0] mdisVec;
	logic                       intOscReq;
	logic                       settleDone;
	logic                       switchDone;
	logic                       primaryDone;
	logic                       wdtOn;
	logic                       fscmOn;
	icg_osc_stat_t              oscStat;

	// Handshakes
	assign awHs    = awvalid & awready;
	assign wHs     = wvalid & wready;
	assign bHs     = bvalid & bready;
	assign arHs    = arvalid & arready;
	assign rHs     = rvalid & rready;
	assign doWrite = awHeld_reg & wHeld_reg & ~bvalid;

	// Byte lanes turned into a bit mask
	assign wMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};

	// Write decode
	assign wrOscCtrl  = doWrite & (awAddr_reg == OFF_OSC_CTRL);
	assign wrPwrCtrl  = doWrite & (awAddr_reg == OFF_PWR_CTRL);
	assign wrPeriphEn = doWrite & (awAddr_reg == OFF_PERIPH_EN);
	assign wrHit      = (awAddr_reg == OFF_OSC_CTRL) | (awAddr_reg == OFF_OSC_STAT)
		| (awAddr_reg == OFF_PWR_CTRL) | (awAddr_reg == OFF_MDIS0)
		| (awAddr_reg == OFF_MDIS1) | (awAddr_reg == OFF_MDIS2)
		| (awAddr_reg == OFF_PERIPH_EN);

	// Merged values; reserved bits are dropped when the register is loaded
	assign oscCtrlMerged  = ({24'h000000, oscCtrl_reg} & ~wMask) | (wData_reg & wMask);
	assign pwrCtrlMerged  = ({30'h00000000, pwrCtrl_reg} & ~wMask) | (wData_reg & wMask);
	assign periphEnMerged = ({{(32-N_PERIPH){1'b0}}, periphEn_reg} & ~wMask)
		| (wData_reg & wMask);

	// Oscillator requests; watchdog and fail-safe keep it running
	assign wdtOn     = pwrCtrl_reg[0];
	assign fscmOn    = pwrCtrl_reg[1];
	assign intOscReq = (oscCtrl_reg.freqSel != 3'h0) | oscCtrl_reg.intSrcSel;

	// Status word from live state
	assign oscStat.rsvd         = 3'h0;
	assign oscStat.inIdle       = (mode_reg == PM_IDLE);
	assign oscStat.cpuRun       = cpuClkEn;
	assign oscStat.intOscOn     = intOscEn;
	assign oscStat.intOscStable = intOscStable;
	assign oscStat.oscStartup   = primaryDone;

	// Read decode; unmapped reads return zero with SLVERR
	assign mdisVec = {mdis_reg[2], mdis_reg[1], mdis_reg[0]};
	assign rdHit   = (araddr == OFF_OSC_CTRL) | (araddr == OFF_OSC_STAT)
		| (araddr == OFF_PWR_CTRL) | (araddr == OFF_MDIS0) | (araddr == OFF_MDIS1)
		| (araddr == OFF_MDIS2) | (araddr == OFF_PERIPH_EN);
	assign rdValue =
		(araddr == OFF_OSC_CTRL)  ? {24'h000000, oscCtrl_reg} :
		(araddr == OFF_OSC_STAT)  ? {24'h000000, oscStat} :
		(araddr == OFF_PWR_CTRL)  ? {30'h00000000, pwrCtrl_reg} :
		(araddr == OFF_MDIS0)     ? {24'h000000, mdis_reg[0]} :
		(araddr == OFF_MDIS1)     ? {24'h000000, mdis_reg[1]} :
		(araddr == OFF_MDIS2)     ? {24'h000000, mdis_reg[2]} :
		(araddr == OFF_PERIPH_EN) ? {{(32-N_PERIPH){1'b0}}, periphEn_reg} :
		32'h00000000;

	// Power mode sequencing
	always_comb
	begin
		mode_next = mode_reg;
		case (mode_reg)
			PM_RUN:
				// Only the internal source with idle select enters this idle
				if (sleepExec & oscCtrl_reg.idleSelect & oscCtrl_reg.clkSrcSelHi)
					mode_next = PM_IDLE;
			PM_IDLE:
				if (wakeEvent)
					mode_next = PM_WAKE;
			PM_WAKE:
				if (switchDone)
					mode_next = PM_RUN;
			default:
				mode_next = PM_RUN;
		endcase
	end

	// Mode register; wake never touches the control word
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			mode_reg <= PM_RUN;
		else
			mode_reg <= mode_next;
	end

	// Clock tree controls, all registered
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cpuClkEn         <= 1'b0;
			cpuClkFromIntOsc <= 1'b0;
			primaryOscEn     <= 1'b0;
			intOscEn         <= 1'b0;
			intOscStable     <= 1'b0;
		end
		else
		begin
			cpuClkEn         <= (mode_next == PM_RUN);
			cpuClkFromIntOsc <= oscCtrl_reg.clkSrcSelHi;
			primaryOscEn     <= ~oscCtrl_reg.clkSrcSelHi;
			intOscEn         <= intOscReq | wdtOn | fscmOn;
			intOscStable     <= settleDone & intOscReq;
		end
	end

	// Internal oscillator settle; keeps counting while enable holds across sleep
	icg_delay_timer #(.CYCLES(SETTLE_CYC)) u_settle (
		.clock (clock),
		.resetn(resetn),
		.run   (intOscEn),
		.done  (settleDone)
	);

	// Clock switch delay after a wake event
	icg_delay_timer #(.CYCLES(SWITCH_CYC)) u_switch (
		.clock (clock),
		.resetn(resetn),
		.run   (mode_reg == PM_WAKE),
		.done  (switchDone)
	);

	// Primary start-up status, cleared as soon as the primary is shut down
	icg_delay_timer #(.CYCLES(PRIMARY_CYC)) u_primary (
		.clock (clock),
		.resetn(resetn),
		.run   (primaryOscEn),
		.done  (primaryDone)
	);

	// Write channel capture; ready drops until the response is taken
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			wHeld_reg  <= 1'b0;
			wData_reg  <= 32'h00000000;
			wStrb_reg  <= 4'h0;
			awready    <= 1'b1;
			wready     <= 1'b1;
		end
		else
		begin
			if (awHs)
				awAddr_reg <= awaddr;
			if (wHs)
			begin
				wData_reg <= wdata;
				wStrb_reg <= wstrb;
			end
			awHeld_reg <= (awHeld_reg | awHs) & ~doWrite;
			wHeld_reg  <= (wHeld_reg | wHs) & ~doWrite;
			awready    <= (awready & ~awHs) | bHs;
			wready     <= (wready & ~wHs) | bHs;
		end
	end

	// Write response
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid <= 1'b1;
			bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bHs)
			bvalid <= 1'b0;
	end

	// Read channel; one read in flight, data sampled at address acceptance
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OKAY;
		end
		else if (arHs)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rdValue;
			rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rHs)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// Oscillator, power and enable registers
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			oscCtrl_reg  <= OSC_CTRL_RST;
			pwrCtrl_reg  <= PWR_CTRL_RST;
			periphEn_reg <= PERIPH_EN_RST;
		end
		else
		begin
			if (wrOscCtrl)
				oscCtrl_reg <= oscCtrlMerged[7:0] & 8'hF7;
			if (wrPwrCtrl)
				pwrCtrl_reg <= pwrCtrlMerged[1:0];
			if (wrPeriphEn)
				periphEn_reg <= periphEnMerged[N_PERIPH-1:0];
		end
	end

	// Module-disable registers, indexed from their offset
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MDIS; gi++)
		begin : g_mdis
			logic wrThis;
			logic [MDIS_W-1:0] merged;
			assign wrThis = doWrite & (awAddr_reg == (OFF_MDIS0 + 8'(4 * gi)));
			assign merged = (mdis_reg[gi] & ~wMask[MDIS_W-1:0])
				| (wData_reg[MDIS_W-1:0] & wMask[MDIS_W-1:0]);
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					mdis_reg[gi] <= MDIS_RST;
				else if (wrThis)
					mdis_reg[gi] <= merged;
			end
		end
	endgenerate

	// Per-peripheral gates; peripheral clocks ignore CPU idle and settle state
	generate
		for (gi = 0; gi < N_PERIPH; gi++)
		begin : g_periph
			icg_periph_gate u_gate (
				.clock     (clock),
				.resetn    (resetn),
				.disableBit(mdisVec[gi]),
				.enableBit (periphEn_reg[gi]),
				.wrReq     (periphWrReq[gi]),
				.clkEn     (periphClkEn[gi]),
				.active    (periphActive[gi]),
				.wrEn      (periphWrEn[gi])
			);
		end
	endgenerate

endmodule

// *** tb/icg_clock_ctrl_properties.sv ***
// Concurrent checks on the idle clock and module gating block.
// Sees only top-level ports; attached to every icg_clock_ctrl by bind.
`timescale 1ns/1ps
module icg_clock_ctrl_properties
	import icg_pkg::*;
#(
	parameter int N_PERIPH = NUM_PERIPH
)
(
	// Clock and reset
	input wire logic                clock,
	input wire logic                resetn,
	// Core events
	input wire logic                sleepExec,
	input wire logic                wakeEvent,
	// Clock tree controls
	input wire logic                cpuClkEn,
	input wire logic                cpuClkFromIntOsc,
	input wire logic                primaryOscEn,
	input wire logic                intOscEn,
	input wire logic                intOscStable,
	// Peripheral gating
	input wire logic [N_PERIPH-1:0] periphWrReq,
	input wire logic [N_PERIPH-1:0] periphClkEn,
	input wire logic [N_PERIPH-1:0] periphActive,
	input wire logic [N_PERIPH-1:0] periphWrEn
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// CPU clock stops only after a sleep taken on the internal mux
	AST_SLEEP_STOPS_CPU:
	assert property ($fell(cpuClkEn) |-> $past(sleepExec) && cpuClkFromIntOsc)
		else $error("cpu clock stopped without a sleep on the internal mux");
	// Restart must not beat the clock switch delay; reset release excluded
	AST_WAKE_WAITS:
	assert property ($rose(cpuClkEn) && $past(resetn, 2) |-> !$past(cpuClkEn, 20))
		else $error("cpu clock restarted too soon after wake");
	AST_PRIMARY_OFF:
	assert property (cpuClkFromIntOsc |-> !primaryOscEn)
		else $error("primary oscillator on while internal mux selected");
	AST_STABLE_AFTER_SETTLE:
	assert property ($rose(intOscStable) |-> intOscEn && $past(intOscEn, 12))
		else $error("stable flag rose before the settle interval");
	AST_IDLE_KEEPS_PERIPH:
	assert property ($fell(cpuClkEn) |-> $stable(periphClkEn) && $stable(intOscEn))
		else $error("idle entry disturbed peripheral clocks");
	AST_FLAGS_HOLD:
	assert property ($fell(cpuClkEn) && $past(intOscStable) |-> intOscStable[*4])
		else $error("stable flag dropped across idle entry");
	AST_WAKE_KEEPS_SRC:
	assert property (wakeEvent && !cpuClkEn |=> ($stable(cpuClkFromIntOsc) && !cpuClkEn)[*8])
		else $error("wake changed source or restarted cpu at once");
	AST_ACTIVE_NEEDS_CLK:
	assert property ((periphActive & ~periphClkEn) == '0)
		else $error("peripheral active with its clock gated");
	AST_WRITE_GATED:
	assert property (periphWrEn == ($past(periphWrReq) & periphClkEn))
		else $error("peripheral write passed while disabled");
endmodule

bind icg_clock_ctrl icg_clock_ctrl_properties #(.N_PERIPH(N_PERIPH)) u_props (
	.clock, .resetn, .sleepExec, .wakeEvent, .cpuClkEn, .cpuClkFromIntOsc, .primaryOscEn,
	.intOscEn, .intOscStable, .periphWrReq, .periphClkEn, .periphActive, .periphWrEn
);

// *** tb/icg_clock_ctrl_tb_top.sv ***
// Self-checking bench for the idle clock and module gating block.
// Drives AXI4-Lite, core events and peripheral write requests directly.
`timescale 1ns/1ps
module icg_clock_ctrl_tb_top
	import icg_pkg::*;
;
	logic                  clock, resetn, sleepExec, wakeEvent;
	logic [7:0]            awaddr, araddr;
	logic [31:0]           wdata, rdata;
	logic [3:0]            wstrb;
	logic [1:0]            bresp, rresp;
	logic                  awvalid, awready, wvalid, wready, bvalid, bready;
	logic                  arvalid, arready, rvalid, rready;
	logic                  cpuClkEn, cpuClkFromIntOsc, primaryOscEn, intOscEn, intOscStable;
	logic [NUM_PERIPH-1:0] periphWrReq, periphClkEn, periphActive, periphWrEn;
	int                    error_cnt = 0;
	int                    compares = 0;

	icg_clock_ctrl dut (
		.clock, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .sleepExec, .wakeEvent, .cpuClkEn, .cpuClkFromIntOsc, .primaryOscEn,
		.intOscEn, .intOscStable, .periphWrReq, .periphClkEn, .periphActive, .periphWrEn
	);

	// 10 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask

	// One write; leading edge keeps a release and a new raise apart
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		bready <= 1'b0;
		chk("bvalid", bvalid, 1'b1);
		chk("bresp", bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		rready <= 1'b0;
		chk("rvalid", rvalid, 1'b1);
		chk("rdata", rdata, ed);
		chk("rresp", rresp, er);
	endtask

	// Last edge lets the sleep edge's updates land before sampling
	task automatic sleep_pulse;
		@(posedge clock);
		sleepExec <= 1'b1;
		@(posedge clock);
		sleepExec <= 1'b0;
		@(posedge clock);
	endtask

	task automatic t_reset;
		cyc(12);
		chk("cpuClkEn", cpuClkEn, 1'b1);
		chk("primaryOscEn", primaryOscEn, 1'b1);
		chk("cpuClkFromIntOsc", cpuClkFromIntOsc, 1'b0);
		chk("periphClkEn", periphClkEn, 24'hFFFFFF);
		chk("intOscEn", intOscEn, 1'b0);
		rd(OFF_OSC_CTRL, 32'h00000000, RESP_OKAY);
		rd(OFF_OSC_STAT, 32'h00000009, RESP_OKAY);
		wr(OFF_OSC_STAT, 32'h000000FF, RESP_OKAY);
		rd(OFF_OSC_STAT, 32'h00000009, RESP_OKAY);
		rd(8'h40, 32'h00000000, RESP_SLVERR);
		wr(8'h40, 32'h00000001, RESP_SLVERR);
	endtask

	task automatic t_osc;
		int n;
		wr(OFF_OSC_CTRL, 32'h00000070, RESP_OKAY);
		cyc(2);
		chk("intOscEn", intOscEn, 1'b1);
		chk("intOscStable", intOscStable, 1'b0);
		n = 0;
		while (!intOscStable && n < 40)
		begin
			@(posedge clock);
			n++;
		end
		chk("intOscStable", intOscStable, 1'b1);
		rd(OFF_OSC_STAT, 32'h0000000F, RESP_OKAY);
		wr(OFF_OSC_CTRL, 32'h00000000, RESP_OKAY);
		wr(OFF_PWR_CTRL, 32'h00000001, RESP_OKAY);
		cyc(20);
		chk("intOscEn", intOscEn, 1'b1);
		chk("intOscStable", intOscStable, 1'b0);
		wr(OFF_PWR_CTRL, 32'h00000002, RESP_OKAY);
		cyc(2);
		chk("intOscEn", intOscEn, 1'b1);
		wr(OFF_PWR_CTRL, 32'h00000000, RESP_OKAY);
		cyc(20);
		chk("intOscEn", intOscEn, 1'b0);
		chk("intOscStable", intOscStable, 1'b0);
	endtask

	task automatic t_idle;
		int n;
		wr(OFF_OSC_CTRL, 32'h00000001, RESP_OKAY);
		sleep_pulse();
		chk("cpuClkEn", cpuClkEn, 1'b1);
		wr(OFF_OSC_CTRL, 32'h000000A5, RESP_OKAY);
		cyc(20);
		chk("primaryOscEn", primaryOscEn, 1'b0);
		chk("cpuClkFromIntOsc", cpuClkFromIntOsc, 1'b1);
		chk("intOscStable", intOscStable, 1'b1);
		rd(OFF_OSC_STAT, 32'h0000000E, RESP_OKAY);
		sleep_pulse();
		chk("cpuClkEn", cpuClkEn, 1'b0);
		chk("periphClkEn", periphClkEn, 24'hFFFFFF);
		chk("intOscStable", intOscStable, 1'b1);
		rd(OFF_OSC_STAT, 32'h00000016, RESP_OKAY);
		wakeEvent <= 1'b1;
		@(posedge clock);
		wakeEvent <= 1'b0;
		n = 0;
		while (!cpuClkEn && n < 60)
		begin
			@(posedge clock);
			n++;
		end
		chk("wake delay", n, SWITCH_CYC + 3);
		rd(OFF_OSC_CTRL, 32'h000000A5, RESP_OKAY);
		wr(OFF_OSC_CTRL, 32'h00000000, RESP_OKAY);
	endtask

	// Peripherals 0, 15 and 20 disabled, one bit in each register
	task automatic t_gate;
		wr(OFF_PERIPH_EN, 32'h00FFFFFF, RESP_OKAY);
		wr(OFF_MDIS0, 32'h00000001, RESP_OKAY);
		wr(OFF_MDIS1, 32'h00000080, RESP_OKAY);
		wr(OFF_MDIS2, 32'h00000010, RESP_OKAY);
		periphWrReq <= 24'hFFFFFF;
		cyc(2);
		chk("periphClkEn", periphClkEn, 24'hEF7FFE);
		chk("periphActive", periphActive, 24'hEF7FFE);
		chk("periphWrEn", periphWrEn, 24'hEF7FFE);
		periphWrReq <= 24'h000000;
		wr(OFF_PERIPH_EN, 32'h00000003, RESP_OKAY);
		cyc(2);
		chk("periphActive", periphActive, 24'h000002);
		chk("periphClkEn", periphClkEn, 24'hEF7FFE);
		rd(OFF_MDIS1, 32'h00000080, RESP_OKAY);
		// Lane 0 strobe off: the disable byte must not change
		wstrb <= 4'hE;
		wr(OFF_MDIS1, 32'h00000000, RESP_OKAY);
		rd(OFF_MDIS1, 32'h00000080, RESP_OKAY);
		wstrb <= 4'hF;
		rd(OFF_PERIPH_EN, 32'h00000003, RESP_OKAY);
		wr(OFF_MDIS0, 32'h00000000, RESP_OKAY);
		cyc(2);
		chk("periphClkEn", periphClkEn, 24'hEF7FFF);
	endtask

	task automatic final_report;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		resetn = 1'b0;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h00000000, 4'hF};
		{awvalid, wvalid, bready, arvalid, rready, sleepExec, wakeEvent} = 7'h00;
		periphWrReq = 24'h000000;
		cyc(8);
		resetn <= 1'b1;
		t_reset();
		t_osc();
		t_idle();
		t_gate();
		final_report();
	end

	// Watchdog: the run needs well under 2000 cycles
	initial
	begin
		#2000000;
		error_cnt++;
		final_report();
	end
endmodule
